// ### design/gsi_top.sv
// global status and interrupt aggregation with Avalon-MM register slave
// assumes port and transmit interface summaries arrive on clk_i; pins and pll locks are async
//
// Notes on behaviour
// - enabled port summary drives interrupt low
// - enabled transmit summary drives interrupt low
// - enabled global summary drives interrupt low
// - live unlock set while any pll unlocked
// - update done is AND of selected ports
// - update done zero while request low
// - 8k activity latched only when selected
// - synthesizer reference activity gets latched
// - one-second bit latched every second
// - unlock latched on live rising edge
// - update done latched on live rising edge
// - second source needs enable and group enable
// - unlock source needs enable and group enable
// - update source needs enable and group enable
// - pin register shows eight pin levels
// - global summary is any enabled latched bit
// - port summary follows port status pending
`timescale 1ns/1ps
`include "gsi_cfg.svh"

module gsi_top
  import gsi_pkg::*;
#(
  parameter int SEC_CYCLES = `GSI_SEC_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic [9:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic [`GSI_NPORT-1:0] port_summary_flag_i,
  input  wire logic                  txsys_summary_flag_i,
  input  wire logic [`GSI_NPORT-1:0] port_perf_update_done_i,
  input  wire logic [`GSI_NPLL-1:0]  pll_locked_i,
  input  wire logic                  synth_ref_clock_pin_i,
  input  wire logic [`GSI_NPIN-1:0]  aux_pin_level_i,
  output logic                       int_n_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  gsi_bus_e                bus_st_r;
  gsi_ctrl_s               ctrl_r;
  gsi_sum_en_s             sum_en_r;
  gsi_lat_t                lat_r;
  gsi_lat_t                lat_en_r;
  logic                    pll_live_r;
  logic                    pll_prev_r;
  logic                    perf_live_r;
  logic                    perf_prev_r;
  logic [24:0]             sec_cnt_r;
  logic                    sec_tick_r;
  logic                    int_n_r;

  logic [`GSI_NPIN-1:0]    pin_sync_w;
  logic [`GSI_NPLL-1:0]    unlock_sync_w;
  logic                    synth_sync_w;
  logic                    ref8k_act_w;
  logic                    synth_act_w;
  logic [7:0]              idx_w;
  logic                    take_w;
  logic                    wr_w;
  gsi_reg_t                wmask_w;
  gsi_reg_t                wdata_w;
  gsi_reg_t                rdata_w;
  gsi_lat_t                set_w;
  gsi_lat_t                clr_w;
  gsi_lat_t                lat_nxt;
  logic                    glob_sum_w;
  logic                    irq_any_w;
  logic                    perf_nxt;

  // ----------------------------------------
  // synchronisers and activity monitors
  // ----------------------------------------
  gsi_sync2 #(.W(`GSI_NPIN)) u_sync_pins (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (aux_pin_level_i),
    .sync_o    (pin_sync_w)
  );

  gsi_sync2 #(.W(`GSI_NPLL + 1)) u_sync_synth (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    // inverted before the flops so the reset value reads as locked
    .async_i   ({synth_ref_clock_pin_i, ~pll_locked_i}),
    .sync_o    ({synth_sync_w, unlock_sync_w})
  );

  // gated sample: an unselected 8k input reads as low, so no activity
  gsi_activity #(.WIN_CYCLES(`GSI_ACT_WIN_CYCLES)) u_act_ref8k (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sample_i  (pin_sync_w[`GSI_PIN_REF8K] & ctrl_r.ref8k_sel),
    .active_o  (ref8k_act_w)
  );

  gsi_activity #(.WIN_CYCLES(`GSI_ACT_WIN_CYCLES)) u_act_synth (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sample_i  (synth_sync_w),
    .active_o  (synth_act_w)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign idx_w   = avs_address_i[9:2];
  assign take_w  = (avs_read_i | avs_write_i) && (bus_st_r == GSI_BUS_IDLE);
  assign wr_w    = take_w && avs_write_i;
  assign wmask_w = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wdata_w = avs_writedata_i[15:0] & wmask_w;

  // one wait cycle, then a single ack cycle with waitrequest low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_st_r <= GSI_BUS_IDLE;
    end else begin
      case (bus_st_r)
        GSI_BUS_IDLE: begin
          if (avs_read_i | avs_write_i) begin
            bus_st_r <= GSI_BUS_ACK;
          end
        end
        GSI_BUS_ACK: begin
          bus_st_r <= GSI_BUS_IDLE;
        end
        default: begin
          bus_st_r <= GSI_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !take_w;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rdata_w = '0;
    case (idx_w)
      `GSI_IDX_SUM_FLAGS: begin
        rdata_w[`GSI_B_PORT_HI:`GSI_B_PORT_LO] = port_summary_flag_i;
        rdata_w[`GSI_B_TXSUM]                  = txsys_summary_flag_i;
        rdata_w[`GSI_B_GSUM]                   = glob_sum_w;
      end
      `GSI_IDX_SUM_EN: begin
        rdata_w[`GSI_B_PORT_HI:`GSI_B_PORT_LO] = sum_en_r.port_en;
        rdata_w[`GSI_B_TXSUM]                  = sum_en_r.tx_en;
        rdata_w[`GSI_B_GSUM]                   = sum_en_r.glob_en;
      end
      `GSI_IDX_LIVE: begin
        rdata_w[`GSI_B_PLL]  = pll_live_r;
        rdata_w[`GSI_B_PERF] = perf_live_r;
      end
      `GSI_IDX_LATCHED: begin
        rdata_w[4:0] = lat_r;
      end
      `GSI_IDX_LAT_EN: begin
        rdata_w[4:0] = lat_en_r;
      end
      `GSI_IDX_PINS: begin
        rdata_w[`GSI_NPIN-1:0] = pin_sync_w;
      end
      `GSI_IDX_CTRL: begin
        rdata_w[`GSI_B_CTRL_REQ]       = ctrl_r.upd_req;
        rdata_w[`GSI_B_CTRL_REF8K]     = ctrl_r.ref8k_sel;
        rdata_w[`GSI_NPORT-1:0]        = ctrl_r.port_sel;
      end
      default: begin
        rdata_w = '0;
      end
    endcase
  end

  // unmapped indices answer zero, never a stall
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= '0;
    end else if (take_w && avs_read_i) begin
      avs_readdata_o <= {16'h0000, rdata_w};
    end
  end

  // ----------------------------------------
  // software writable registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sum_en_r <= gsi_sum_en_s'(`GSI_SUM_EN_RST);
    end else if (wr_w && idx_w == `GSI_IDX_SUM_EN) begin
      sum_en_r.port_en <= (sum_en_r.port_en & ~wmask_w[`GSI_B_PORT_HI:`GSI_B_PORT_LO])
                          | wdata_w[`GSI_B_PORT_HI:`GSI_B_PORT_LO];
      sum_en_r.tx_en   <= wmask_w[`GSI_B_TXSUM] ? wdata_w[`GSI_B_TXSUM] : sum_en_r.tx_en;
      sum_en_r.glob_en <= wmask_w[`GSI_B_GSUM] ? wdata_w[`GSI_B_GSUM] : sum_en_r.glob_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lat_en_r <= gsi_lat_t'(`GSI_LAT_EN_RST);
    end else if (wr_w && idx_w == `GSI_IDX_LAT_EN) begin
      lat_en_r <= (lat_en_r & ~wmask_w[4:0]) | (wdata_w[4:0] & gsi_lat_t'(`GSI_LAT_EN_MASK));
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= gsi_ctrl_s'(`GSI_CTRL_RST);
    end else if (wr_w && idx_w == `GSI_IDX_CTRL) begin
      ctrl_r.upd_req   <= wmask_w[`GSI_B_CTRL_REQ] ? wdata_w[`GSI_B_CTRL_REQ] : ctrl_r.upd_req;
      ctrl_r.ref8k_sel <= wmask_w[`GSI_B_CTRL_REF8K] ? wdata_w[`GSI_B_CTRL_REF8K] : ctrl_r.ref8k_sel;
      ctrl_r.port_sel  <= (ctrl_r.port_sel & ~wmask_w[`GSI_NPORT-1:0]) | wdata_w[`GSI_NPORT-1:0];
    end
  end

  // ----------------------------------------
  // live status
  // ----------------------------------------
  // no selected port means nothing was requested, so done stays low
  assign perf_nxt = ctrl_r.upd_req && (|ctrl_r.port_sel)
                    && (&(port_perf_update_done_i | ~ctrl_r.port_sel));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pll_live_r  <= 1'b0;
      pll_prev_r  <= 1'b0;
      perf_live_r <= 1'b0;
      perf_prev_r <= 1'b0;
    end else begin
      pll_live_r  <= |unlock_sync_w;
      pll_prev_r  <= pll_live_r;
      perf_live_r <= perf_nxt;
      perf_prev_r <= perf_live_r;
    end
  end

  // ----------------------------------------
  // one-second timebase
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sec_cnt_r  <= '0;
      sec_tick_r <= 1'b0;
    end else if (sec_cnt_r == 25'(SEC_CYCLES - 1)) begin
      sec_cnt_r  <= '0;
      sec_tick_r <= 1'b1;
    end else begin
      sec_cnt_r  <= sec_cnt_r + 25'h0000001;
      sec_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // latched status
  // ----------------------------------------
  always_comb begin
    set_w                = '0;
    set_w[`GSI_B_PERF]   = perf_live_r & ~perf_prev_r;
    set_w[`GSI_B_PLL]    = pll_live_r & ~pll_prev_r;
    set_w[`GSI_B_SEC]    = sec_tick_r;
    set_w[`GSI_B_SYNTH]  = synth_act_w;
    set_w[`GSI_B_REF8K]  = ref8k_act_w;
  end

  assign clr_w   = (wr_w && idx_w == `GSI_IDX_LATCHED) ? wdata_w[4:0] : '0;
  assign lat_nxt = (lat_r & ~clr_w) | set_w;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lat_r <= `GSI_LAT_RST;
    end else begin
      lat_r <= lat_nxt;
    end
  end

  // ----------------------------------------
  // summaries and interrupt pin
  // ----------------------------------------
  assign glob_sum_w = |(lat_r & lat_en_r);

  assign irq_any_w = (|(port_summary_flag_i & sum_en_r.port_en))
                     | (txsys_summary_flag_i & sum_en_r.tx_en)
                     | (glob_sum_w & sum_en_r.glob_en);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= ~irq_any_w;
    end
  end

  assign int_n_o = int_n_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_req_taken;
    take_w;
  endsequence

  sequence s_ack_cycle;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  property p_bus_ack;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_req_taken |=> s_ack_cycle;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus ack not one cycle after take");

  property p_port_irq;
    @(posedge clk_i) disable iff (sys_rst_i)
      (|(port_summary_flag_i & sum_en_r.port_en)) |=> !int_n_o;
  endproperty
  a_port_irq: assert property (p_port_irq) else $error("enabled port flag did not assert int");

  property p_tx_irq;
    @(posedge clk_i) disable iff (sys_rst_i)
      (txsys_summary_flag_i && sum_en_r.tx_en) |=> !int_n_o;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("enabled transmit flag did not assert int");

  property p_glob_irq;
    @(posedge clk_i) disable iff (sys_rst_i)
      (|(lat_r & lat_en_r)) && sum_en_r.glob_en |=> !int_n_o;
  endproperty
  a_glob_irq: assert property (p_glob_irq) else $error("enabled global flag did not assert int");

  property p_pll_live;
    @(posedge clk_i) disable iff (sys_rst_i)
      (unlock_sync_w != '0) |=> pll_live_r;
  endproperty
  a_pll_live: assert property (p_pll_live) else $error("unlock live bit not set");

  property p_perf_idle;
    @(posedge clk_i) disable iff (sys_rst_i)
      !ctrl_r.upd_req |=> !perf_live_r;
  endproperty
  a_perf_idle: assert property (p_perf_idle) else $error("update done high without request");

  property p_perf_and;
    @(posedge clk_i) disable iff (sys_rst_i)
      ctrl_r.upd_req && (ctrl_r.port_sel != '0)
      && ((port_perf_update_done_i & ctrl_r.port_sel) == ctrl_r.port_sel) |=> perf_live_r;
  endproperty
  a_perf_and: assert property (p_perf_and) else $error("update done missing when all ports done");

  sequence s_pll_rise;
    !pll_live_r ##1 pll_live_r;
  endsequence

  property p_pll_latch;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_pll_rise |=> lat_r[`GSI_B_PLL];
  endproperty
  a_pll_latch: assert property (p_pll_latch) else $error("unlock rise not latched");

  property p_perf_latch;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(perf_live_r) |=> lat_r[`GSI_B_PERF];
  endproperty
  a_perf_latch: assert property (p_perf_latch) else $error("update done rise not latched");

  property p_sec_irq;
    @(posedge clk_i) disable iff (sys_rst_i)
      sec_tick_r && lat_en_r[`GSI_B_SEC] && sum_en_r.glob_en |=> ##1 !int_n_o;
  endproperty
  a_sec_irq: assert property (p_sec_irq) else $error("second tick did not reach int");

  property p_sticky;
    @(posedge clk_i) disable iff (sys_rst_i)
      ##1 ((($past(lat_r) & ~$past(clr_w)) & ~lat_r) == '0);
  endproperty
  a_sticky: assert property (p_sticky) else $error("latched bit lost without clear");

  property p_release;
    @(posedge clk_i) disable iff (sys_rst_i)
      !irq_any_w |=> int_n_o;
  endproperty
  a_release: assert property (p_release) else $error("int held with no enabled source");

  property p_pins_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      take_w && avs_read_i && (idx_w == `GSI_IDX_PINS)
      |=> avs_readdata_o[`GSI_NPIN-1:0] == $past(pin_sync_w);
  endproperty
  a_pins_read: assert property (p_pins_read) else $error("pin read value wrong");

endmodule

// ### design/gsi_cfg.svh
// constants of the global status and interrupt block
// assumes a 20 MHz system clock and a 32-bit Avalon-MM slave port
`ifndef GSI_CFG_SVH
`define GSI_CFG_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define GSI_CLK_HZ          20000000
`define GSI_CLK_PERIOD_NS   50
`define GSI_SEC_S           1
`define GSI_SEC_CYCLES      (`GSI_CLK_HZ * `GSI_SEC_S)
`define GSI_ACT_WIN_NS      200000
`define GSI_ACT_WIN_CYCLES  (`GSI_ACT_WIN_NS / `GSI_CLK_PERIOD_NS)

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define GSI_IDX_SUM_FLAGS   8'h10
`define GSI_IDX_SUM_EN      8'h12
`define GSI_IDX_LIVE        8'h14
`define GSI_IDX_LATCHED     8'h16
`define GSI_IDX_LAT_EN      8'h18
`define GSI_IDX_PINS        8'h1c
`define GSI_IDX_CTRL        8'h20

// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define GSI_SUM_EN_MASK     16'h00f3
`define GSI_LAT_EN_MASK     16'h0007
`define GSI_CTRL_MASK       16'h011f
`define GSI_SUM_EN_RST      16'h0000
`define GSI_LAT_EN_RST      16'h0000
`define GSI_CTRL_RST        16'h0000
`define GSI_LAT_RST         5'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define GSI_B_PERF          0
`define GSI_B_PLL           1
`define GSI_B_SEC           2
`define GSI_B_SYNTH         3
`define GSI_B_REF8K         4
`define GSI_B_GSUM          0
`define GSI_B_TXSUM         1
`define GSI_B_PORT_LO       4
`define GSI_B_PORT_HI       7
`define GSI_B_CTRL_REF8K    4
`define GSI_B_CTRL_REQ      8
`define GSI_PIN_REF8K       3
`define GSI_NPORT           4
`define GSI_NPLL            3
`define GSI_NPIN            8

`endif

// ### design/gsi_pkg.sv
// types of the global status and interrupt block
// assumes gsi_cfg.svh for the port count; latch and register widths are fixed here
`include "gsi_cfg.svh"

package gsi_pkg;

  typedef logic [4:0]  gsi_lat_t;
  typedef logic [15:0] gsi_reg_t;

  typedef struct packed {
    logic                      upd_req;
    logic                      ref8k_sel;
    logic [`GSI_NPORT-1:0]     port_sel;
  } gsi_ctrl_s;

  typedef struct packed {
    logic [`GSI_NPORT-1:0]     port_en;
    logic                      tx_en;
    logic                      glob_en;
  } gsi_sum_en_s;

  typedef enum logic {
    GSI_BUS_IDLE,
    GSI_BUS_ACK
  } gsi_bus_e;

endpackage

// ### design/gsi_sync2.sv
// two-flop synchroniser for a vector of levels
// assumes each bit is an independent slow level
`timescale 1ns/1ps

module gsi_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// ### design/gsi_activity.sv
// activity detector: reports a level that saw edges within a window
// assumes sample_i is already synchronous to clk_i
`timescale 1ns/1ps

module gsi_activity #(
  parameter int WIN_CYCLES = 4000
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sample_i,
  output logic      active_o
);

  logic [12:0] win_cnt_r;
  logic        prev_r;
  logic        seen_r;
  logic        edge_w;
  logic        win_end_w;

  assign edge_w    = sample_i ^ prev_r;
  assign win_end_w = (win_cnt_r == 13'(WIN_CYCLES - 1));

  // fast clocks alias when sampled, but still toggle often enough
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      win_cnt_r <= '0;
      prev_r    <= 1'b0;
      seen_r    <= 1'b0;
      active_o  <= 1'b0;
    end else begin
      prev_r <= sample_i;
      if (win_end_w) begin
        win_cnt_r <= '0;
        active_o  <= seen_r | edge_w;
        seen_r    <= 1'b0;
      end else begin
        win_cnt_r <= win_cnt_r + 13'h0001;
        seen_r    <= seen_r | edge_w;
      end
    end
  end

endmodule

// ### test/test_gsi_top.sv
// self-checking bench for the global status and interrupt block
// assumes gsi_top as the device; the bench drives every port itself
`timescale 1ns/1ps
`include "gsi_cfg.svh"

module test_gsi_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int SEC = 3000; // short second so the tick shows in a short run
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [9:0]  adr       = '0;
  logic        rd_en     = 1'b0;
  logic        wr_en     = 1'b0;
  logic [31:0] wdat      = '0;
  logic [3:0]  be        = 4'hf;
  logic [31:0] rdat;
  logic        wreq;
  logic [3:0]  port_flg  = '0;
  logic        tx_flg    = 1'b0;
  logic [3:0]  port_done = '0;
  logic [2:0]  locked    = 3'h7;
  logic        ref_pin   = 1'b0;
  logic [7:0]  pins      = '0;
  logic        int_n;
  logic [31:0] seed      = 32'hc1044400;
  int          err_total = 0;
  int          tests_run = 0;
  logic [31:0] exp_q[$]; // {mask, value} per read

  always #25 clk_i = ~clk_i;

  gsi_top #(.SEC_CYCLES(SEC)) dut (
    .clk_i                   (clk_i),
    .sys_rst_i               (sys_rst_i),
    .avs_address_i           (adr),
    .avs_read_i              (rd_en),
    .avs_write_i             (wr_en),
    .avs_writedata_i         (wdat),
    .avs_byteenable_i        (be),
    .avs_readdata_o          (rdat),
    .avs_waitrequest_o       (wreq),
    .port_summary_flag_i     (port_flg),
    .txsys_summary_flag_i    (tx_flg),
    .port_perf_update_done_i (port_done),
    .pll_locked_i            (locked),
    .synth_ref_clock_pin_i   (ref_pin),
    .aux_pin_level_i         (pins),
    .int_n_o                 (int_n)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one transfer; upper write bits random since the slave ignores them
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d, input logic [3:0] b);
    int n;
    n = 0;
    seed = xs(seed);
    adr <= {idx, 2'b00};
    wdat <= {seed[31:16], d};
    be <= b;
    rd_en <= ~w;
    wr_en <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      err_total++;
      conclude();
    end
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk_i); // idle cycle: slave is back in its idle state here
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] m, input logic [15:0] e);
    exp_q.push_back({m, e});
    bus(1'b0, idx, 16'h0000, 4'hf);
  endtask

  task automatic chk_int(input logic e);
    check("int_n_o", {15'h0, int_n}, {15'h0, e});
  endtask

  task automatic toggle();
    repeat (8200) begin
      @(posedge clk_i);
      ref_pin <= ~ref_pin;
      pins[3] <= ~pins[3];
    end
  endtask

  // ----------------------------------------
  // read monitor
  // ----------------------------------------
  always @(posedge clk_i) begin
    logic [31:0] e;
    if (rd_en && wreq === 1'b0) begin
      e = exp_q.pop_front();
      check("readdata", rdat[15:0] & e[31:16], e[15:0]);
    end
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  localparam logic [7:0]  RI [7] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1c, 8'h20};
  localparam logic [7:0]  TI [6] = '{8'h12, 8'h12, 8'h18, 8'h20, 8'h14, 8'h3f};
  localparam logic [3:0]  TB [6] = '{4'h2, 4'h1, 4'hf, 4'hf, 4'hf, 4'hf};
  localparam logic [15:0] TE [6] = '{16'h0000, 16'h00f3, 16'h0007, 16'h011f, 16'h0000, 16'h0000};

  initial begin
    logic [4:0]  v;
    logic [15:0] e;
    cyc(6);
    sys_rst_i <= 1'b0;
    cyc(1);
    foreach (RI[i]) rd(RI[i], 16'hffff, 16'h0000);
    chk_int(1'b1);
    foreach (TI[i]) begin
      bus(1'b1, TI[i], 16'hffff, TB[i]);
      rd(TI[i], 16'hffff, TE[i]);
      wr(TI[i], 16'h0000);
    end
    repeat (4) begin
      seed = xs(seed);
      e = {8'h00, seed[7:0]};
      pins <= seed[7:0];
      cyc(3);
      rd(8'h1c, 16'hffff, e);
    end
    // port and transmit groups, each masked then enabled
    for (int i = 0; i < 5; i++) begin
      v = 5'h01 << i;
      e = {8'h00, v[4:1], 2'b00, v[0], 1'b0};
      {port_flg, tx_flg} <= v;
      wr(8'h12, 16'h00f2 & ~e);
      chk_int(1'b1);
      wr(8'h12, e);
      chk_int(1'b0);
      rd(8'h10, 16'hffff, e);
    end
    {port_flg, tx_flg} <= 5'h00;
    cyc(2);
    chk_int(1'b1);
    // pll unlock
    wr(8'h18, 16'h0002);
    wr(8'h12, 16'h0001);
    locked <= 3'b101;
    cyc(6);
    rd(8'h14, 16'hffff, 16'h0002);
    chk_int(1'b0);
    rd(8'h10, 16'hffff, 16'h0001);
    locked <= 3'h7;
    cyc(6);
    rd(8'h14, 16'hffff, 16'h0000);
    rd(8'h16, 16'h0003, 16'h0002);
    wr(8'h12, 16'h0000);
    chk_int(1'b1);
    wr(8'h12, 16'h0001);
    wr(8'h18, 16'h0000);
    chk_int(1'b1);
    wr(8'h18, 16'h0002);
    chk_int(1'b0);
    wr(8'h16, 16'h0002);
    rd(8'h16, 16'h0003, 16'h0000);
    chk_int(1'b1);
    // performance update done
    wr(8'h18, 16'h0001);
    wr(8'h20, 16'h0103);
    port_done <= 4'b1101;
    cyc(3);
    rd(8'h14, 16'h0001, 16'h0000);
    chk_int(1'b1);
    port_done <= 4'b0011;
    cyc(3);
    rd(8'h14, 16'h0001, 16'h0001);
    rd(8'h16, 16'h0001, 16'h0001);
    chk_int(1'b0);
    wr(8'h18, 16'h0000);
    chk_int(1'b1);
    wr(8'h20, 16'h0003);
    rd(8'h14, 16'h0001, 16'h0000);
    wr(8'h16, 16'h0001);
    // one-second tick
    wr(8'h18, 16'h0004);
    wr(8'h16, 16'h0004);
    chk_int(1'b1);
    cyc(SEC + 20);
    rd(8'h16, 16'h0004, 16'h0004);
    chk_int(1'b0);
    wr(8'h18, 16'h0000);
    chk_int(1'b1);
    // activity: 8k input unselected, then selected
    wr(8'h20, 16'h0000);
    toggle();
    rd(8'h16, 16'h0018, 16'h0008);
    wr(8'h20, 16'h0010);
    wr(8'h16, 16'h0018);
    toggle();
    rd(8'h16, 16'h0018, 16'h0018);
    cyc(2);
    conclude();
  end
endmodule
